// ---- core/aps_conv.sv ----
// Converter end: decodes control words, acquires, converts, flags done.
// Assumes the host on aps_link_if; analog value supplied as a sample word.

`timescale 1ns/10ps
`default_nettype none

module aps_conv #(
   parameter int CONV_CYC = aps_pkg::CONV_CYC
) (
   input wire logic clk, // Clock
   input wire logic arst_n, // Async reset, active low
   input wire logic [aps_pkg::RES_W-1:0] sample, // Value to convert
   output logic [2:0] channel, // Selected analog input channel
   output logic int_clk, // High once internal clock selected
   output logic powered, // High while not powered down
   aps_link_if.conv link // Host link
);
   logic int_clk_r;
   logic acq_r;
   logic conv_r;
   logic full_down_r;
   logic pwr_r;
   logic done_n_r;
   logic [aps_pkg::RES_W-1:0] res_r;
   logic [2:0] ch_r;
   logic [15:0] cnt_r;
   logic [1:0] pwr_code;
   logic acq_sel;

   assign pwr_code = link.ctrl_word[aps_pkg::CW_PWR_HI_BIT:aps_pkg::CW_PWR_LO_BIT];
   assign acq_sel = link.ctrl_word[aps_pkg::CW_ACQ_BIT];
   wire wr_ok = link.wr_strobe && link.shutdown_n;
   wire conv_start = wr_ok && pwr_code[1] && !acq_sel;

   // ----------------------------------------------------------------
   // Clock mode and power state
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         int_clk_r <= 1'b0; // RULE_01
      end else if (wr_ok && pwr_code == aps_pkg::PWR_CLK_INT) begin
         int_clk_r <= 1'b1;
      end else if (wr_ok && pwr_code == aps_pkg::PWR_CLK_EXT) begin
         int_clk_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acq_r <= 1'b0;
         conv_r <= 1'b0;
         full_down_r <= 1'b0;
         pwr_r <= 1'b0;
         ch_r <= '0;
         cnt_r <= '0;
      end else if (!link.shutdown_n) begin
         acq_r <= 1'b0;
         conv_r <= 1'b0;
         pwr_r <= 1'b0;
      end else if (conv_start) begin
         acq_r <= 1'b0;
         conv_r <= 1'b1; // RULE_06 RULE_11
         pwr_r <= 1'b1;
         full_down_r <= pwr_code == aps_pkg::PWR_FULL_DOWN;
         ch_r <= link.ctrl_word[2:0];
         cnt_r <= 16'(CONV_CYC);
      end else if (wr_ok && pwr_code[1] && acq_sel) begin
         acq_r <= 1'b1; // RULE_11
         pwr_r <= 1'b1;
         ch_r <= link.ctrl_word[2:0];
      end else if (conv_r) begin
         cnt_r <= cnt_r - 16'h0001;
         if (cnt_r == 16'h0001) begin
            conv_r <= 1'b0;
            pwr_r <= !full_down_r; // Standby keeps power, full-down drops it
         end
      end
   end

   // Done low at completion; released by the next control write or read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         done_n_r <= 1'b1;
         res_r <= '0;
      end else if (conv_r && cnt_r == 16'h0001) begin
         done_n_r <= 1'b0; // RULE_07
         res_r <= sample;
      end else if (link.rd_strobe || wr_ok) begin
         done_n_r <= 1'b1;
      end
   end

   assign link.done_n = done_n_r;
   assign link.result = res_r;
   assign channel = ch_r;
   assign int_clk = int_clk_r;
   assign powered = pwr_r || acq_r;
endmodule : aps_conv

`default_nettype wire

// ---- core/aps_delay.sv ----
// Down-counting delay timer used for power-up and acquisition waits.
// Assumes a one-cycle start pulse; load value in clock cycles.

`timescale 1ns/10ps
`default_nettype none

module aps_delay #(
   parameter int W = aps_pkg::DLY_W
) (
   input wire logic clk, // Clock
   input wire logic arst_n, // Async reset
   input wire logic start, // Load pulse
   input wire logic [W-1:0] load, // Cycles to wait
   output logic expired // One-cycle end pulse
);
   logic [W-1:0] cnt_r;
   logic run_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         run_r <= 1'b0;
      end else if (start) begin
         cnt_r <= load;
         run_r <= 1'b1;
      end else if (run_r) begin
         if (cnt_r <= W'(1)) begin
            run_r <= 1'b0;
         end
         cnt_r <= (cnt_r == '0) ? '0 : cnt_r - W'(1);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         expired <= 1'b0;
      end else begin
         expired <= run_r && !start && cnt_r <= W'(1);
      end
   end
endmodule : aps_delay

`default_nettype wire

// ---- core/aps_host.sv ----
// Host end: sequences control words, shutdown pin and result reads.
// Assumes software on a plain strobe port; converter on aps_link_if.
//
// Functional notes
// RULE_01 - Converter starts in external clock mode
// RULE_02 - Host init switches converter to internal clock
// RULE_03 - Acquisition select zero unless external acquisition
// RULE_04 - External reference skips power-up wait
// RULE_05 - Internal reference waits after power-up, wake
// RULE_06 - Standby code converts once then stands by
// RULE_07 - Done low marks result ready for read
// RULE_08 - Full-down: standby, wait, then code 1,1
// RULE_09 - Wake with standby before full-down conversion
// RULE_10 - Pin cycling: raise, wait, convert, read, lower
// RULE_11 - External acquisition: sample write, then convert write
// RULE_12 - Host times the acquisition interval
// RULE_13 - External full-down: wake, wait, acquire, convert
// RULE_14 - No control writes during conversion
//
// Chosen here: the address-and-strobe port and the register addresses.

`timescale 1ns/10ps
`default_nettype none

module aps_host (
   input wire logic clk, // Clock
   input wire logic arst_n, // Async reset, active low
   input wire logic [aps_pkg::ADDR_W-1:0] addr, // Register address
   input wire logic [31:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [31:0] rdata, // Read data, cycle after rd
   output logic irq, // Level interrupt
   aps_link_if.host link // Converter link
);
   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_PIN_UP = 9'h002,
      ST_WAKE = 9'h004,
      ST_PU_WAIT = 9'h008,
      ST_ACQ = 9'h010,
      ST_ACQ_WAIT = 9'h020,
      ST_CONV = 9'h040,
      ST_WAIT_DONE = 9'h080,
      ST_READ = 9'h100
   } aps_state_e;

   aps_state_e state_r;
   logic [31:0] ctrl_r;
   logic [aps_pkg::DLY_W-1:0] pu_dly_r;
   logic [aps_pkg::DLY_W-1:0] acq_dly_r;
   logic [aps_pkg::RES_W-1:0] result_r;
   logic [aps_pkg::IRQ_W-1:0] irq_stat_r;
   logic [aps_pkg::IRQ_W-1:0] irq_mask_r;
   logic done_s1_r;
   logic done_s2_r;
   logic init_pend_r;
   logic wr_r;
   logic [aps_pkg::CW_W-1:0] cw_r;
   logic rd_r;
   logic shdn_n_r;
   logic dly_start;
   logic [aps_pkg::DLY_W-1:0] dly_load;
   logic dly_expired;
   logic ev_done;
   logic ev_refused;
   logic busy;

   wire ext_acq = ctrl_r[aps_pkg::CTRL_EXT_ACQ_BIT];
   wire full_down = ctrl_r[aps_pkg::CTRL_FULL_DOWN_BIT];
   wire use_pin = ctrl_r[aps_pkg::CTRL_USE_PIN_BIT];
   wire ext_ref = ctrl_r[aps_pkg::CTRL_EXT_REF_BIT];
   wire go_wr = wr && addr == aps_pkg::REG_CMD && wdata[aps_pkg::CMD_GO_BIT];
   wire init_wr = wr && addr == aps_pkg::REG_CMD && wdata[aps_pkg::CMD_INIT_BIT];

   assign busy = state_r != ST_IDLE;

   // Build a control word: power code, acquisition select, low five bits kept.
   function automatic logic [aps_pkg::CW_W-1:0] mk_cw(input logic [1:0] pwr,
                                                     input logic acq,
                                                     input logic [5:0] low);
      mk_cw = {pwr, acq, low[4:0]};
   endfunction : mk_cw

   // Channel field only; clock-select and range bits left at zero here.
   wire [5:0] low_bits = {3'h0, ctrl_r[aps_pkg::CTRL_CH_LSB +: 3]} & aps_pkg::CW_LOW_MASK;

   // ----------------------------------------------------------------
   // Done line synchroniser (pin from the converter)
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         done_s1_r <= 1'b1;
         done_s2_r <= 1'b1;
      end else begin
         done_s1_r <= link.done_n;
         done_s2_r <= done_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (go_wr && !init_pend_r) begin
                  if (use_pin) begin
                     state_r <= ST_PIN_UP; // RULE_10
                  end else if (full_down) begin
                     state_r <= ST_WAKE; // RULE_09
                  end else if (ext_acq) begin
                     state_r <= ST_ACQ; // RULE_11
                  end else begin
                     state_r <= ST_CONV; // RULE_06
                  end
               end
            end
            ST_PIN_UP: state_r <= ext_ref ? (ext_acq ? ST_ACQ : ST_CONV) : ST_PU_WAIT; // RULE_04
            ST_WAKE: state_r <= ext_ref ? (ext_acq ? ST_ACQ : ST_CONV) : ST_PU_WAIT; // RULE_05
            ST_PU_WAIT: begin
               if (dly_expired) begin
                  state_r <= ext_acq ? ST_ACQ : ST_CONV; // RULE_08
               end
            end
            ST_ACQ: state_r <= ST_ACQ_WAIT;
            ST_ACQ_WAIT: begin
               if (dly_expired) begin
                  state_r <= ST_CONV; // RULE_12
               end
            end
            ST_CONV: state_r <= ST_WAIT_DONE;
            ST_WAIT_DONE: begin
               if (!done_s2_r) begin
                  state_r <= ST_READ; // RULE_07
               end
            end
            ST_READ: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Delay timer starts on entry to each wait
   assign dly_start = (state_r == ST_PIN_UP || state_r == ST_WAKE) && !ext_ref
                      || state_r == ST_ACQ;
   assign dly_load = (state_r == ST_ACQ) ? acq_dly_r : pu_dly_r;

   aps_delay #(.W(aps_pkg::DLY_W)) u_delay (
      .clk(clk),
      .arst_n(arst_n),
      .start(dly_start),
      .load(dly_load),
      .expired(dly_expired)
   );

   // ----------------------------------------------------------------
   // Link drive: control word writes, result read, shutdown pin
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_r <= 1'b0;
         cw_r <= '0;
      end else begin
         wr_r <= 1'b0;
         if (state_r == ST_IDLE && init_pend_r) begin
            wr_r <= 1'b1;
            cw_r <= mk_cw(aps_pkg::PWR_CLK_INT, 1'b0, low_bits); // RULE_02
         end else if (state_r == ST_WAKE) begin
            wr_r <= 1'b1;
            cw_r <= mk_cw(aps_pkg::PWR_STANDBY, 1'b0, low_bits); // RULE_09
         end else if (state_r == ST_ACQ) begin
            wr_r <= 1'b1;
            cw_r <= mk_cw(aps_pkg::PWR_STANDBY, 1'b1, low_bits); // RULE_11
         end else if (state_r == ST_CONV) begin
            wr_r <= 1'b1;
            // Full-down code only when no shutdown pin is in use
            cw_r <= mk_cw((full_down && !use_pin) ? aps_pkg::PWR_FULL_DOWN
                          : aps_pkg::PWR_STANDBY, 1'b0, low_bits); // RULE_03 RULE_08 RULE_13
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         init_pend_r <= 1'b0;
      end else if (init_wr && !busy) begin
         init_pend_r <= 1'b1;
      end else if (state_r == ST_IDLE) begin
         init_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_r <= 1'b0;
         result_r <= '0;
      end else begin
         rd_r <= state_r == ST_WAIT_DONE && !done_s2_r;
         if (state_r == ST_READ) begin
            result_r <= link.result; // RULE_07
         end
      end
   end

   // Pin stays high after reset if the pin sequence is not used
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shdn_n_r <= 1'b1;
      end else if (state_r == ST_IDLE && go_wr && use_pin) begin
         shdn_n_r <= 1'b1;
      end else if (state_r == ST_IDLE && use_pin) begin
         shdn_n_r <= 1'b0; // RULE_10
      end else if (state_r == ST_IDLE) begin
         shdn_n_r <= 1'b1;
      end
   end

   assign link.wr_strobe = wr_r;
   assign link.ctrl_word = cw_r;
   assign link.rd_strobe = rd_r;
   assign link.shutdown_n = shdn_n_r;

   // ----------------------------------------------------------------
   // Registers and interrupts
   // ----------------------------------------------------------------
   assign ev_done = state_r == ST_READ;
   assign ev_refused = (go_wr || init_wr) && busy; // RULE_14

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= aps_pkg::CTRL_RESET;
         pu_dly_r <= aps_pkg::PU_DLY_RESET;
         acq_dly_r <= aps_pkg::ACQ_DLY_RESET;
         irq_mask_r <= '0;
      end else if (wr) begin
         case (addr)
            aps_pkg::REG_CTRL: if (!busy) ctrl_r <= wdata; // RULE_14
            aps_pkg::REG_PU_DLY: pu_dly_r <= wdata[aps_pkg::DLY_W-1:0];
            aps_pkg::REG_ACQ_DLY: acq_dly_r <= wdata[aps_pkg::DLY_W-1:0];
            aps_pkg::REG_IRQ_MASK: irq_mask_r <= wdata[aps_pkg::IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Set wins over write-one-to-clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r
                        & ~((wr && addr == aps_pkg::REG_IRQ_STAT) ? wdata[aps_pkg::IRQ_W-1:0]
                            : '0))
                       | {ev_refused, ev_done};
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= '0;
      end else if (rd) begin
         case (addr)
            aps_pkg::REG_CTRL: rdata <= ctrl_r;
            aps_pkg::REG_STATUS: rdata <= {22'h0, init_pend_r, state_r};
            aps_pkg::REG_RESULT: rdata <= {16'h0, result_r};
            aps_pkg::REG_IRQ_STAT: rdata <= {30'h0, irq_stat_r};
            aps_pkg::REG_IRQ_MASK: rdata <= {30'h0, irq_mask_r};
            aps_pkg::REG_PU_DLY: rdata <= {8'h0, pu_dly_r};
            aps_pkg::REG_ACQ_DLY: rdata <= {8'h0, acq_dly_r};
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end
endmodule : aps_host

`default_nettype wire

// ---- core/aps_link_if.sv ----
// Link between the host sequencer and the converter model.
// Assumes one clock for both parties.

`timescale 1ns/10ps
`default_nettype none

interface aps_link_if;
   logic wr_strobe;
   logic [aps_pkg::CW_W-1:0] ctrl_word;
   logic rd_strobe;
   logic [aps_pkg::RES_W-1:0] result;
   logic done_n;
   logic shutdown_n;

   modport host (
      output wr_strobe, ctrl_word, rd_strobe, shutdown_n,
      input result, done_n
   );
   modport conv (
      input wr_strobe, ctrl_word, rd_strobe, shutdown_n,
      output result, done_n
   );
endinterface : aps_link_if

`default_nettype wire

// ---- core/aps_pkg.sv ----
// Package for the acquisition power sequencer: control word layout,
// power codes, host register map and timing counts.
// Assumes a 100 MHz clock shared by both ends.

package aps_pkg;

   // ----------------------------------------------------------------
   // Control word layout (8 bits on the converter bus)
   // ----------------------------------------------------------------
   localparam int CW_W = 8;
   localparam int CW_PWR_HI_BIT = 7;
   localparam int CW_PWR_LO_BIT = 6;
   localparam int CW_ACQ_BIT = 5;
   localparam logic [5:0] CW_LOW_MASK = 6'h3f;
   localparam int RES_W = 16;

   // Power mode codes {upper, lower}
   localparam logic [1:0] PWR_STANDBY = 2'h2;
   localparam logic [1:0] PWR_FULL_DOWN = 2'h3;
   localparam logic [1:0] PWR_CLK_EXT = 2'h0;
   localparam logic [1:0] PWR_CLK_INT = 2'h1;

   // ----------------------------------------------------------------
   // Host register map (word addresses)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_RESULT = 4'h3;
   localparam logic [3:0] REG_IRQ_STAT = 4'h4;
   localparam logic [3:0] REG_IRQ_MASK = 4'h5;
   localparam logic [3:0] REG_PU_DLY = 4'h6;
   localparam logic [3:0] REG_ACQ_DLY = 4'h7;

   // Command register: write 1 to start
   localparam int CMD_GO_BIT = 0;
   localparam int CMD_INIT_BIT = 1;

   // Control register fields
   localparam int CTRL_EXT_ACQ_BIT = 0;
   localparam int CTRL_FULL_DOWN_BIT = 1;
   localparam int CTRL_USE_PIN_BIT = 2;
   localparam int CTRL_EXT_REF_BIT = 3;
   localparam int CTRL_CH_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Interrupt status bits
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_REFUSED_BIT = 1;
   localparam int IRQ_W = 2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int CONV_TIME_NS = 6000;
   localparam int CONV_CYC = CONV_TIME_NS * CLK_MHZ / 1000;
   localparam int DLY_W = 24;
   localparam logic [23:0] PU_DLY_RESET = 24'h00_0400;
   localparam logic [23:0] ACQ_DLY_RESET = 24'h00_0040;

endpackage : aps_pkg

// ---- tb/aps_link_props.sv ----
// Checker for the converter link between the host and converter ends.
// Assumes one clock domain; instantiated beside the link in the bench.

`timescale 1ns/10ps
`default_nettype none

module aps_link_props #(
   parameter int CONV_CYC = aps_pkg::CONV_CYC
) (
   input wire logic clk, // Clock
   input wire logic arst_n, // Async reset, active low
   input wire logic wr_strobe, // Control word strobe
   input wire logic [aps_pkg::CW_W-1:0] ctrl_word, // Control word
   input wire logic rd_strobe, // Result read strobe
   input wire logic [aps_pkg::RES_W-1:0] result, // Conversion result
   input wire logic done_n, // Completion, active low
   input wire logic shutdown_n // Power pin, active low
);
   localparam int CMAX = CONV_CYC + 4;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // ---------------------------------------------------------------
   // Link sequences
   // ---------------------------------------------------------------
   sequence s_acq;
      wr_strobe && ctrl_word[aps_pkg::CW_ACQ_BIT];
   endsequence
   sequence s_full_conv;
      wr_strobe && ctrl_word[7:5] == 3'h6;
   endsequence

   AST_ACQ_STANDBY: assert property (s_acq |-> ctrl_word[7:6] == aps_pkg::PWR_STANDBY)
      else $error("acquire word without standby code");
   AST_ACQ_HOLD: assert property (s_acq |=> !wr_strobe [*4])
      else $error("convert word too soon after acquire word");
   AST_CONV_EARLY: assert property (s_full_conv |=> done_n [*8])
      else $error("done flagged too early");
   AST_CONV_DONE: assert property (s_full_conv |-> ##[1:CMAX] !done_n)
      else $error("conversion never completed");
   AST_READ_AFTER_DONE: assert property ($fell(done_n) |-> ##[2:6] rd_strobe)
      else $error("result not read after done");
   AST_READ_ON_DONE: assert property (rd_strobe |-> !done_n)
      else $error("result read before done");
   AST_DONE_HOLD: assert property ((!done_n && !rd_strobe && !wr_strobe) |=> !done_n)
      else $error("done released without read");
   // Result is loaded on the edge that drops done, so stability is judged one cycle on
   AST_RESULT_STABLE: assert property (!done_n |=> $stable(result))
      else $error("result changed while done low");
   AST_NO_WR_DONE: assert property (!done_n |-> !wr_strobe)
      else $error("control write while result pending");
   AST_PIN_QUIET: assert property (!shutdown_n |-> !wr_strobe)
      else $error("control write while pin shut down");

endmodule : aps_link_props

`default_nettype wire

// ---- tb/test_adc_power_acquisition_sequencer.sv ----
// Bench joining host and converter ends over the link.
// Assumes short delay registers and a short conversion parameter.

`timescale 1ns/10ps
`default_nettype none

module test_adc_power_acquisition_sequencer;
   localparam int CONV = 20;
   localparam int DLY = 8;
   logic clk, arst_n, wr, rd, irq, int_clk, powered;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [15:0] sample;
   logic [2:0] channel;
   int miscompares, total_checks, cyc;
   logic [7:0] words[$];
   int stamps[$];

   aps_link_if link();
   aps_host aps_host_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .irq(irq), .link(link));
   aps_conv #(.CONV_CYC(CONV)) aps_conv_i (.clk(clk), .arst_n(arst_n), .sample(sample),
      .channel(channel), .int_clk(int_clk), .powered(powered), .link(link));
   aps_link_props #(.CONV_CYC(CONV)) aps_link_props_i (.clk(clk), .arst_n(arst_n),
      .wr_strobe(link.wr_strobe), .ctrl_word(link.ctrl_word), .rd_strobe(link.rd_strobe),
      .result(link.result), .done_n(link.done_n), .shutdown_n(link.shutdown_n));

   // ---------------------------------------------------------------
   // Clock, link monitor, hang guard
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (link.wr_strobe === 1'b1) begin
         words.push_back(link.ctrl_word);
         stamps.push_back(cyc);
      end
      if (cyc == 20000) begin
         miscompares++;
         test_done();
      end
   end

   // ---------------------------------------------------------------
   // Access and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic wait_irq();
      for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h1);
   endtask : wait_irq

   // One go command in a mode; n link words expected, first gap bounded
   task automatic run_case(input logic [3:0] mode, input logic [2:0] ch, input int n,
         input logic [7:0] w0, input logic [7:0] w1, input logic [7:0] w2,
         input int gmin, input int gmax);
      logic [31:0] d;
      logic [7:0] w;
      @(posedge clk);
      sample <= {ch, 13'h0abc};
      wr_reg(aps_pkg::REG_CTRL, {21'h0, ch, 4'h0, mode});
      words.delete();
      stamps.delete();
      wr_reg(aps_pkg::REG_CMD, 32'h1);
      wait_irq();
      rd_reg(aps_pkg::REG_RESULT, d);
      chk(d, {16'h0, sample});
      chk(words.size(), n);
      for (int i = 0; i < n && i < words.size(); i++) begin
         w = (i == 0) ? w0 : (i == 1) ? w1 : w2;
         chk(words[i], {w[7:3], ch});
      end
      if (n > 1 && words.size() > 1)
         chk(stamps[1] - stamps[0] >= gmin && stamps[1] - stamps[0] <= gmax, 1);
      chk(channel, ch);
      rd_reg(aps_pkg::REG_IRQ_STAT, d);
      chk(d[1:0], 2'h1);
      wr_reg(aps_pkg::REG_IRQ_STAT, 32'h3);
      #1 chk(irq, 1'b0);
   endtask : run_case

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] d;
      arst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      sample = 16'h0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      #1 chk(int_clk, 1'b0);
      rd_reg(aps_pkg::REG_CTRL, d);
      chk(d, aps_pkg::CTRL_RESET);
      rd_reg(aps_pkg::REG_PU_DLY, d);
      chk(d, {8'h0, aps_pkg::PU_DLY_RESET});
      rd_reg(aps_pkg::REG_ACQ_DLY, d);
      chk(d, {8'h0, aps_pkg::ACQ_DLY_RESET});
      rd_reg(aps_pkg::REG_STATUS, d);
      chk(d, 32'h1);
      rd_reg(4'hf, d);
      chk(d, 32'h0);
      wr_reg(aps_pkg::REG_PU_DLY, DLY);
      wr_reg(aps_pkg::REG_ACQ_DLY, DLY);
      wr_reg(aps_pkg::REG_CMD, 32'h2);
      for (int k = 0; k < 100 && int_clk !== 1'b1; k++) @(posedge clk);
      chk(int_clk, 1'b1);
      wr_reg(aps_pkg::REG_IRQ_STAT, 32'h3);
      wr_reg(aps_pkg::REG_IRQ_MASK, 32'h1);
      run_case(4'h0, 3'h1, 1, 8'h80, 8'h0, 8'h0, 0, 0);
      chk(powered, 1'b1);
      run_case(4'h2, 3'h2, 2, 8'h80, 8'hc0, 8'h0, DLY, 999);
      chk(powered, 1'b0);
      run_case(4'h4, 3'h3, 1, 8'h80, 8'h0, 8'h0, 0, 0);
      chk(link.shutdown_n, 1'b0);
      chk(powered, 1'b0);
      run_case(4'h1, 3'h4, 2, 8'ha0, 8'h80, 8'h0, DLY, 999);
      run_case(4'h3, 3'h5, 3, 8'h80, 8'ha0, 8'hc0, DLY, 999);
      run_case(4'ha, 3'h6, 2, 8'h80, 8'hc0, 8'h0, 1, DLY - 1);
      // Second go while busy must be refused and flagged
      wr_reg(aps_pkg::REG_CTRL, 32'h0);
      wr_reg(aps_pkg::REG_CMD, 32'h1);
      wr_reg(aps_pkg::REG_CMD, 32'h1);
      wait_irq();
      rd_reg(aps_pkg::REG_IRQ_STAT, d);
      chk(d[1:0], 2'h3);
      wr_reg(aps_pkg::REG_IRQ_STAT, 32'h1);
      wr_reg(aps_pkg::REG_IRQ_MASK, 32'h0);
      #1 chk(irq, 1'b0);
      wr_reg(aps_pkg::REG_IRQ_MASK, 32'h2);
      #1 chk(irq, 1'b1);
      wr_reg(aps_pkg::REG_IRQ_STAT, 32'h2);
      #1 chk(irq, 1'b0);
      test_done();
   end

endmodule : test_adc_power_acquisition_sequencer

`default_nettype wire
